//--- logic/sup_timer.sv
// supervision timer: reload counter, feed check, enable lock and reset cause
//
// Behaviour
// - once enabled, expiry without reload fires the configured reset or interrupt; valid reloads restart
// - software may enable but never disable; only reset or a timer event disables
// - wrong or unfinished feed while enabled fires the configured reset or interrupt
// - a readable flag shows the last chip reset came from this timer
// - 32-bit loadable counter advanced through a built-in prescaler
// - period steps of four timer clocks, from 256x4 up to 2^32x4
// - timer clock chosen from rtc clock, internal rc oscillator, or bus clock
`timescale 1ns/1ps
`default_nettype none
module sup_timer (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        POR,
   input  wire logic [1:0]  CLK_SEL,
   input  wire logic        RC_OSC_TICK,
   input  wire logic        RTC_TICK,
   input  wire logic        ENABLE_SET,
   input  wire logic        RESET_MODE,
   input  wire logic        LOAD_WR,
   input  wire logic [31:0] LOAD_VALUE,
   input  wire logic        FEED_WR,
   input  wire logic [7:0]  FEED_DATA,
   input  wire logic        OTHER_WR,
   input  wire logic        CAUSE_CLR,
   output logic             CHIP_RESET_REQ,
   output logic             INT_REQ,
   output logic             ENABLED,
   output logic             CAUSE_FLAG,
   output logic [31:0]      COUNT
);
   sup_timer_pkg::feed_state_t feed_ff;
   sup_timer_pkg::feed_state_t nxt_feed;
   logic [31:0]                cnt_ff;
   logic [31:0]                nxt_cnt;
   logic [31:0]                load_ff;
   logic [31:0]                nxt_load;
   logic                       en_ff;
   logic                       nxt_en;
   logic                       rst_req_ff;
   logic                       nxt_rst_req;
   logic                       int_ff;
   logic                       nxt_int;
   logic                       cause_ff;
   logic                       nxt_cause;
   logic                       good_feed;
   logic                       bad_feed;
   logic                       expire;
   logic                       fire;
   logic                       tick;

   sup_tick_if tif ();

   // ****************************************
   // tick source
   // ****************************************
   assign tif.sel      = CLK_SEL;
   assign tif.rc_osc_tick = RC_OSC_TICK;
   assign tif.rtc_tick = RTC_TICK;
   assign tick         = tif.tick;

   sup_tick_prescaler u_presc (
      .clk (CLK),
      .rst (RST),
      .tif (tif)
   );

   // values 1..255 give the shortest period, 0 gives the longest
   function automatic logic [31:0] clamp_load(input logic [31:0] v);
      if ((v != 32'h0000_0000) && (v < sup_timer_pkg::LOAD_MIN)) begin
         clamp_load = sup_timer_pkg::LOAD_MIN;
      end else begin
         clamp_load = v;
      end
   endfunction

   // ****************************************
   // feed sequence
   // ****************************************
   always_comb begin
      good_feed = 1'b0;
      bad_feed  = 1'b0;
      nxt_feed  = feed_ff;
      case (feed_ff)
         sup_timer_pkg::FEED_IDLE: begin
            if (FEED_WR) begin
               if (FEED_DATA == sup_timer_pkg::FEED_KEY_1) begin
                  nxt_feed = sup_timer_pkg::FEED_ARMED;
               end else begin
                  bad_feed = 1'b1;
               end
            end
         end
         sup_timer_pkg::FEED_ARMED: begin
            if (OTHER_WR) begin
               bad_feed = 1'b1;
               nxt_feed = sup_timer_pkg::FEED_IDLE;
            end else if (FEED_WR) begin
               nxt_feed = sup_timer_pkg::FEED_IDLE;
               if (FEED_DATA == sup_timer_pkg::FEED_KEY_2) begin
                  good_feed = 1'b1;
               end else begin
                  bad_feed = 1'b1;
               end
            end
         end
         default: begin
            nxt_feed = sup_timer_pkg::FEED_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         feed_ff <= sup_timer_pkg::FEED_IDLE;
      end else begin
         feed_ff <= nxt_feed;
      end
   end

   // ****************************************
   // counter, enable and response
   // ****************************************
   always_comb begin
      expire      = en_ff && tick && (cnt_ff == sup_timer_pkg::COUNT_EXPIRE);
      fire        = expire || (en_ff && bad_feed);
      nxt_load    = LOAD_WR ? clamp_load(LOAD_VALUE) : load_ff;
      nxt_en      = en_ff;
      nxt_cnt     = cnt_ff;
      nxt_rst_req = fire && RESET_MODE;
      nxt_int     = fire && !RESET_MODE;
      if (fire) begin
         nxt_en  = 1'b0;
         nxt_cnt = load_ff;
      end else begin
         if (ENABLE_SET) begin
            nxt_en = 1'b1;
         end
         if (good_feed || (ENABLE_SET && !en_ff)) begin
            nxt_cnt = load_ff;
         end else if (en_ff && tick) begin
            nxt_cnt = cnt_ff - 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         en_ff      <= 1'b0;
         cnt_ff     <= sup_timer_pkg::LOAD_RESET;
         load_ff    <= sup_timer_pkg::LOAD_RESET;
         rst_req_ff <= 1'b0;
         int_ff     <= 1'b0;
      end else begin
         en_ff      <= nxt_en;
         cnt_ff     <= nxt_cnt;
         load_ff    <= nxt_load;
         rst_req_ff <= nxt_rst_req;
         int_ff     <= nxt_int;
      end
   end

   // ****************************************
   // reset cause flag
   // ****************************************
   always_comb begin
      nxt_cause = cause_ff;
      if (CAUSE_CLR) begin
         nxt_cause = 1'b0;
      end
      if (nxt_rst_req) begin
         nxt_cause = 1'b1;
      end
   end

   // kept across the chip reset it causes, cleared by CAUSE_CLR or at power-on
   always_ff @(posedge CLK) begin
      if (POR) begin
         cause_ff <= 1'b0;
      end else begin
         cause_ff <= nxt_cause;
      end
   end

   assign CHIP_RESET_REQ = rst_req_ff;
   assign INT_REQ        = int_ff;
   assign ENABLED        = en_ff;
   assign CAUSE_FLAG     = cause_ff;
   assign COUNT          = cnt_ff;

   // ****************************************
   // checks
   // ****************************************
   chk_expire_resets: assert property (@(posedge CLK) disable iff (RST)
      (en_ff && tick && cnt_ff == sup_timer_pkg::COUNT_EXPIRE && RESET_MODE)
      |=> CHIP_RESET_REQ && !ENABLED)
      else $error("expiry did not request a chip reset");

   chk_feed_reloads: assert property (@(posedge CLK) disable iff (RST)
      (en_ff && good_feed && !expire) |=> COUNT == $past(load_ff))
      else $error("valid feed did not reload the counter");

   chk_no_sw_disable: assert property (@(posedge CLK) disable iff (RST)
      (en_ff && !fire) |=> ENABLED)
      else $error("timer disabled without a timer event");

   chk_bad_feed_fires: assert property (@(posedge CLK) disable iff (RST)
      (en_ff && FEED_WR && feed_ff == sup_timer_pkg::FEED_IDLE
         && FEED_DATA != sup_timer_pkg::FEED_KEY_1)
      |=> (CHIP_RESET_REQ || INT_REQ) ##1 !(CHIP_RESET_REQ || INT_REQ))
      else $error("wrong feed key did not fire a one-cycle response");

   chk_armed_abort: assert property (@(posedge CLK) disable iff (RST)
      (en_ff && OTHER_WR && feed_ff == sup_timer_pkg::FEED_ARMED && !RESET_MODE)
      |=> INT_REQ && !CHIP_RESET_REQ)
      else $error("unfinished feed did not raise the interrupt");

   chk_cause_set: assert property (@(posedge CLK) disable iff (POR)
      CHIP_RESET_REQ |-> CAUSE_FLAG)
      else $error("reset cause flag missing after timer reset");

   chk_count_step: assert property (@(posedge CLK) disable iff (RST)
      (en_ff && tick && !fire && !good_feed && !ENABLE_SET)
      |=> COUNT == $past(cnt_ff) - 32'h0000_0001)
      else $error("counter did not step down on a prescaled tick");

   chk_min_period: assert property (@(posedge CLK) disable iff (RST)
      (LOAD_WR && LOAD_VALUE != 32'h0000_0000 && LOAD_VALUE < sup_timer_pkg::LOAD_MIN)
      |=> load_ff == sup_timer_pkg::LOAD_MIN)
      else $error("short timeout not raised to the minimum");
endmodule
`default_nettype wire

//--- logic/sup_timer_pkg.sv
// constants shared by the supervision timer and its tick prescaler
`default_nettype none
package sup_timer_pkg;
   localparam logic [1:0]  SEL_RC_OSC    = 2'h0;
   localparam logic [1:0]  SEL_PCLK      = 2'h1;
   localparam logic [1:0]  SEL_RTC       = 2'h2;
   localparam logic [1:0]  PRESC_LAST    = 2'h3;
   localparam logic [1:0]  PRESC_RESET   = 2'h0;
   localparam logic [7:0]  FEED_KEY_1    = 8'hAA;
   localparam logic [7:0]  FEED_KEY_2    = 8'h55;
   localparam logic [31:0] LOAD_MIN      = 32'h0000_0100;
   localparam logic [31:0] LOAD_RESET    = 32'h0000_0100;
   localparam logic [31:0] COUNT_EXPIRE  = 32'h0000_0001;
   typedef enum logic {FEED_IDLE, FEED_ARMED} feed_state_t;
endpackage
`default_nettype wire

//--- logic/sup_tick_if.sv
// tick source selection and prescaled tick between timer and prescaler
`timescale 1ns/1ps
`default_nettype none
interface sup_tick_if;
   logic [1:0] sel;
   logic       rc_osc_tick;
   logic       rtc_tick;
   logic       tick;
   modport presc (input sel, input rc_osc_tick, input rtc_tick, output tick);
   modport timer (output sel, output rc_osc_tick, output rtc_tick, input tick);
endinterface
`default_nettype wire

//--- logic/sup_tick_prescaler.sv
// clock source select and divide-by-four prescaler for the supervision timer
`timescale 1ns/1ps
`default_nettype none
module sup_tick_prescaler (
   input  wire logic    clk,
   input  wire logic    rst,
   sup_tick_if.presc    tif
);
   logic [1:0] div_ff;
   logic [1:0] nxt_div;
   logic       src_tick;

   // ****************************************
   // source select and divider
   // ****************************************
   always_comb begin
      case (tif.sel)
         sup_timer_pkg::SEL_RC_OSC: src_tick = tif.rc_osc_tick;
         sup_timer_pkg::SEL_PCLK: src_tick = 1'b1;
         sup_timer_pkg::SEL_RTC:  src_tick = tif.rtc_tick;
         default:                 src_tick = 1'b0;
      endcase
      nxt_div = src_tick ? div_ff + 2'h1 : div_ff;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         div_ff <= sup_timer_pkg::PRESC_RESET;
      end else begin
         div_ff <= nxt_div;
      end
   end

   assign tif.tick = src_tick && (div_ff == sup_timer_pkg::PRESC_LAST);

   // ****************************************
   // checks
   // ****************************************
   chk_tick_spacing: assert property (@(posedge clk) disable iff (rst)
      tif.tick |=> !tif.tick [*3])
      else $error("prescaled tick came sooner than four source ticks");
endmodule
`default_nettype wire

//--- dv/sup_timer_tb.sv
// self-checking bench for the supervision timer
`timescale 1ns/1ps
`default_nettype none
module sup_timer_tb;
   logic        CLK, RST, POR, RC_OSC_TICK, RTC_TICK, ENABLE_SET, RESET_MODE;
   logic        LOAD_WR, FEED_WR, OTHER_WR, CAUSE_CLR;
   logic [1:0]  CLK_SEL;
   logic [31:0] LOAD_VALUE;
   logic [7:0]  FEED_DATA;
   logic        CHIP_RESET_REQ, INT_REQ, ENABLED, CAUSE_FLAG;
   logic [31:0] COUNT;
   int          fail_count, num_checks, cycles, n;
   logic [31:0] c0;

   sup_timer i_dut (.CLK(CLK), .RST(RST), .POR(POR), .CLK_SEL(CLK_SEL),
      .RC_OSC_TICK(RC_OSC_TICK), .RTC_TICK(RTC_TICK), .ENABLE_SET(ENABLE_SET),
      .RESET_MODE(RESET_MODE), .LOAD_WR(LOAD_WR), .LOAD_VALUE(LOAD_VALUE),
      .FEED_WR(FEED_WR), .FEED_DATA(FEED_DATA), .OTHER_WR(OTHER_WR),
      .CAUSE_CLR(CAUSE_CLR), .CHIP_RESET_REQ(CHIP_RESET_REQ), .INT_REQ(INT_REQ),
      .ENABLED(ENABLED), .CAUSE_FLAG(CAUSE_FLAG), .COUNT(COUNT));

   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge CLK) begin
      cycles++;
      if (cycles == 10000) begin
         fail_count++;
         $display("wrong value at %0t: run did not finish", $time);
         summarize;
      end
   end

   task automatic tick(input int k);
      repeat (k) @(negedge CLK);
   endtask

   task automatic enable;
      ENABLE_SET = 1'b1;
      tick(1);
      ENABLE_SET = 1'b0;
   endtask

   task automatic feed(input logic [7:0] d);
      FEED_DATA = d;
      FEED_WR = 1'b1;
      tick(1);
      FEED_WR = 1'b0;
   endtask

   task automatic other;
      OTHER_WR = 1'b1;
      tick(1);
      OTHER_WR = 1'b0;
   endtask

   task automatic reset_chip(input logic por_too);
      RST = 1'b1;
      POR = por_too;
      tick(5);
      RST = 1'b0;
      POR = 1'b0;
   endtask

   // wait for either response pulse, counting cycles
   task automatic wait_fire;
      n = 0;
      while (CHIP_RESET_REQ !== 1'b1 && INT_REQ !== 1'b1 && n < 1200) begin
         tick(1);
         n++;
      end
   endtask

   task automatic t_expiry;
      CLK_SEL = sup_timer_pkg::SEL_PCLK;
      RESET_MODE = 1'b1;
      chk(ENABLED, 0, "disabled after reset");
      chk(COUNT, sup_timer_pkg::LOAD_RESET, "count after reset");
      enable;
      chk(ENABLED, 1, "enabled");
      other;
      chk(ENABLED, 1, "write never disables");
      wait_fire;
      chk(n >= 1015 && n <= 1030, 1, "period 256x4");
      chk({INT_REQ, ENABLED, CAUSE_FLAG}, 3'h1, "reset response");
      tick(1);
      chk(CHIP_RESET_REQ, 0, "one cycle pulse");
      $display("test expiry done");
   endtask

   task automatic t_feed;
      enable;
      tick(100);
      other;
      feed(sup_timer_pkg::FEED_KEY_1);
      tick(3);
      feed(sup_timer_pkg::FEED_KEY_2);
      chk(COUNT, sup_timer_pkg::LOAD_RESET, "feed reloads");
      wait_fire;
      chk(n >= 1015 && n <= 1030, 1, "period restarted");
      chk(CHIP_RESET_REQ, 1, "reset after feed");
      $display("test feed done");
   endtask

   task automatic t_badfeed;
      RESET_MODE = 1'b0;
      CAUSE_CLR = 1'b1;
      tick(1);
      CAUSE_CLR = 1'b0;
      chk(CAUSE_FLAG, 0, "flag cleared");
      for (int k = 0; k < 3; k++) begin
         enable;
         if (k != 1) begin
            feed(sup_timer_pkg::FEED_KEY_1);
            tick(1);
         end
         if (k == 0) other;
         else feed(k == 1 ? sup_timer_pkg::FEED_KEY_2 : 8'h12);
         wait_fire;
         chk(n <= 2, 1, "fault fires at once");
         chk({CHIP_RESET_REQ, INT_REQ, ENABLED, CAUSE_FLAG}, 4'h4, "interrupt");
         tick(1);
      end
      $display("test bad feed done");
   endtask

   task automatic t_load;
      RESET_MODE = 1'b1;
      LOAD_VALUE = 32'h0000_0001;
      LOAD_WR = 1'b1;
      tick(1);
      LOAD_WR = 1'b0;
      enable;
      chk(COUNT, 32'h0000_0100, "short load clamps");
      wait_fire;
      LOAD_VALUE = 32'h0000_0200;
      LOAD_WR = 1'b1;
      tick(1);
      LOAD_WR = 1'b0;
      enable;
      chk(COUNT, 32'h0000_0200, "loaded count");
      reset_chip(1'b0);
      chk({ENABLED, CAUSE_FLAG}, 2'h1, "chip reset keeps flag");
      LOAD_VALUE = 32'h0000_0000;
      LOAD_WR = 1'b1;
      tick(1);
      LOAD_WR = 1'b0;
      enable;
      chk(COUNT, 32'h0000_0000, "zero load kept");
      tick(4);
      chk(COUNT, 32'hFFFF_FFFF, "zero load wraps to longest");
      reset_chip(1'b1);
      chk(CAUSE_FLAG, 0, "power-on clears flag");
      $display("test load done");
   endtask

   // eight source ticks make two counter steps; no source, no steps
   task automatic t_sources;
      for (int s = 0; s < 3; s++) begin
         CLK_SEL = (s == 0) ? sup_timer_pkg::SEL_RC_OSC
                 : (s == 1) ? sup_timer_pkg::SEL_RTC : 2'h3;
         enable;
         c0 = COUNT;
         repeat (8) begin
            RC_OSC_TICK = (s != 1);
            RTC_TICK = (s != 0);
            tick(1);
            RC_OSC_TICK = (s == 1);
            RTC_TICK = (s == 0);
            tick(1);
            RC_OSC_TICK = 1'b0;
            RTC_TICK = 1'b0;
            tick(2);
         end
         chk(COUNT, c0 - ((s == 2) ? 32'h0 : 32'h2), "prescaled source");
         reset_chip(1'b0);
      end
      $display("test sources done");
   endtask

   initial begin
      {RC_OSC_TICK, RTC_TICK, ENABLE_SET, RESET_MODE, LOAD_WR, FEED_WR} = '0;
      {OTHER_WR, CAUSE_CLR} = '0;
      CLK_SEL = sup_timer_pkg::SEL_PCLK;
      LOAD_VALUE = '0;
      FEED_DATA = '0;
      fail_count = 0;
      num_checks = 0;
      cycles = 0;
      reset_chip(1'b1);
      t_expiry;
      t_feed;
      t_badfeed;
      t_load;
      t_sources;
      summarize;
   end
endmodule
`default_nettype wire
